// ---- rtl/rate_repartition_pkg.sv ----
//==============================================================
// Operation
// - Lead time counts superframes from first EXEC/EXEC ACK 1 to new framing.
// - Lead time is a fixed parameter agreed before activation.
// - Idle master sends MONITOR 0; entered on reset, framer ready, NAK.
// - Idle master starts on supervisor order or received REQUEST.
// - Idle master alarms when upstream MONITOR slot map differs from own.
// - Master initiation sends DEMAND, counter from 1, per superframe.
// - DEMAND ACK moves master to go-ahead-1, starting transmit framer.
// - DEMAND NAK returns master idle with slave-not-ready notice.
// - Master counters stop at 15 with overflow notice.
// - Go-ahead-1 sends EXEC from 1; EXEC ACK starts receive framer.
// - Go-ahead-2 holds EXEC count; framer ready ends with completion.
// - Idle slave sends MONITOR 0; entered from listed states and events.
// - Idle slave: DEMAND to confirm if ready, else not-ready; request with ready to slave-request.
// - Slave-request sends REQUEST from 1; DEMAND moves to confirmation.
// - Confirmation sends DEMAND ACK with triggering DEMAND sequence.
// - EXEC in confirmation starts both framers and reports EXEC sequence.
// - Not-ready sends DEMAND NAK with DEMAND sequence; MONITOR aborts.
// - Slave go-ahead sends EXEC ACK from 1; framer or message picks wait.
// - Slave EXEC ACK counter stops at 15 with overflow notice.
// - Wait states hold count; remaining event returns idle with completion.
// - Control channel uses 1 to 3 Z bits; over seven merge to B.
// - Message is type nibble, sequence nibble, then slot-map octets.
// - Type codes are fixed per message kind.
// - Three copies per superframe; majority of two decides.
// - One message per superframe; changes occur at superframe boundaries. Supervisory reset here acts in any cycle.
//==============================================================
package rate_repartition_pkg;
   localparam logic [3:0] MSG_MONITOR = 4'hf;
   localparam logic [3:0] MSG_DEMAND = 4'he;
   localparam logic [3:0] MSG_DEMAND_ACK = 4'hd;
   localparam logic [3:0] MSG_DEMAND_NAK = 4'hb;
   localparam logic [3:0] MSG_EXEC = 4'h1;
   localparam logic [3:0] MSG_EXEC_ACK = 4'h4;
   localparam logic [3:0] MSG_REQUEST = 4'hc;
   localparam logic [3:0] SEQ_IDLE = 4'h0;
   localparam logic [3:0] SEQ_FIRST = 4'h1;
   localparam logic [3:0] SEQ_MAX = 4'hf;
   localparam int TYPE_POS = 4;
   localparam int ZBIT_MIN = 1;
   localparam int ZBIT_MAX = 3;
   localparam int ZBIT_MERGE = 8;
   localparam int COPIES = 3;
   localparam int LEAD_DEFAULT = 2;
   typedef enum {M_IDLE, M_INIT, M_GO1, M_GO2} mst_t;
   typedef enum {S_IDLE, S_REQ, S_CONF, S_NRDY, S_GO, S_WMON, S_WFRM} slv_t;
endpackage

// ---- rtl/rate_repartition.sv ----
`timescale 1ns/1ps
module rate_repartition #(
   parameter int SLOTS = 8,
   parameter int ZBITS = 1,
   parameter int LEAD_TIME = rate_repartition_pkg::LEAD_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic is_master,
   input wire logic superframe,
   input wire logic sup_reset,
   input wire logic sup_start,
   input wire logic slave_ready,
   input wire logic slave_request,
   input wire logic framer_ready,
   input wire logic [SLOTS-1:0] local_map,
   input wire logic [SLOTS/8*8+7:0] rx_copy0,
   input wire logic [SLOTS/8*8+7:0] rx_copy1,
   input wire logic [SLOTS/8*8+7:0] rx_copy2,
   output logic [SLOTS/8*8+7:0] tx_msg,
   output logic start_tx_framer,
   output logic start_rx_framer,
   output logic done,
   output logic aborted,
   output logic not_ready,
   output logic overflow,
   output logic slot_alarm,
   output logic exec_seq_valid,
   output logic [3:0] exec_seq,
   output logic [3:0] lead_time,
   output logic [1:0] zbit_count
);
   localparam int W = SLOTS / 8 * 8 + 8;

   // Elaboration checks on channel sizing
   initial begin
      if (SLOTS < 8 || SLOTS % 8 != 0 || SLOTS > 24)
         $error("SLOTS must be 8, 16 or 24");
      if (ZBITS < rate_repartition_pkg::ZBIT_MIN || ZBITS > rate_repartition_pkg::ZBIT_MAX)
         $error("ZBITS must be 1 to 3");
      if (LEAD_TIME < 1 || LEAD_TIME > 15)
         $error("LEAD_TIME out of range");
   end

   //==========================================================
   // State
   typedef struct packed {
      rate_repartition_pkg::mst_t m;
      rate_repartition_pkg::slv_t s;
      logic [3:0] seq;
      logic [W-1:0] msg;
      logic stx;
      logic srx;
      logic dn;
      logic ab;
      logic nr;
      logic ov;
      logic al;
      logic ev;
      logic [3:0] es;
   } state_t;

   state_t q, d;
   logic [W-1:0] rx;
   logic [3:0] rtype;
   logic [3:0] rseq;
   logic [3:0] inc;

   // Majority vote of the three copies
   assign rx = (rx_copy0 & rx_copy1) | (rx_copy0 & rx_copy2) | (rx_copy1 & rx_copy2);
   assign rtype = rx[W-1 -: 4];
   assign rseq = rx[W-5 -: 4];
   assign inc = (q.seq == rate_repartition_pkg::SEQ_MAX) ? q.seq : q.seq + 4'h1;

   //==========================================================
   // Next state, stepped on each superframe and on supervisory reset
   always_comb begin
      d = q;
      d.stx = 1'b0;
      d.srx = 1'b0;
      d.dn = 1'b0;
      d.ab = 1'b0;
      d.nr = 1'b0;
      d.ev = 1'b0;
      d.ov = 1'b0;
      if (superframe) begin
         if (is_master) begin
            d.s = rate_repartition_pkg::S_IDLE;
            unique case (q.m)
               rate_repartition_pkg::M_IDLE: begin
                  d.seq = rate_repartition_pkg::SEQ_IDLE;
                  d.al = (rtype == rate_repartition_pkg::MSG_MONITOR)
                     && (rx[SLOTS-1:0] != local_map);
                  if (sup_start || rtype == rate_repartition_pkg::MSG_REQUEST) begin
                     d.m = rate_repartition_pkg::M_INIT;
                     d.seq = rate_repartition_pkg::SEQ_FIRST;
                  end
               end
               rate_repartition_pkg::M_INIT: begin
                  if (rtype == rate_repartition_pkg::MSG_DEMAND_ACK) begin
                     d.m = rate_repartition_pkg::M_GO1;
                     d.stx = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_FIRST;
                  end else if (rtype == rate_repartition_pkg::MSG_DEMAND_NAK) begin
                     d.m = rate_repartition_pkg::M_IDLE;
                     d.nr = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end else begin
                     d.seq = inc;
                     d.ov = (inc == rate_repartition_pkg::SEQ_MAX);
                  end
               end
               rate_repartition_pkg::M_GO1: begin
                  if (rtype == rate_repartition_pkg::MSG_EXEC_ACK) begin
                     d.m = rate_repartition_pkg::M_GO2;
                     d.srx = 1'b1;
                  end else begin
                     d.seq = inc;
                     d.ov = (inc == rate_repartition_pkg::SEQ_MAX);
                  end
               end
               rate_repartition_pkg::M_GO2: begin
                  if (framer_ready) begin
                     d.m = rate_repartition_pkg::M_IDLE;
                     d.dn = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end
               end
            endcase
         end else begin
            d.m = rate_repartition_pkg::M_IDLE;
            d.al = 1'b0;
            // Unlisted messages leave the state as is
            unique case (q.s)
               rate_repartition_pkg::S_IDLE: begin
                  d.seq = rate_repartition_pkg::SEQ_IDLE;
                  if (rtype == rate_repartition_pkg::MSG_DEMAND) begin
                     d.s = slave_ready ? rate_repartition_pkg::S_CONF : rate_repartition_pkg::S_NRDY;
                     d.seq = rseq;
                  end else if (slave_request && slave_ready) begin
                     d.s = rate_repartition_pkg::S_REQ;
                     d.seq = rate_repartition_pkg::SEQ_FIRST;
                  end
               end
               rate_repartition_pkg::S_REQ: begin
                  if (rtype == rate_repartition_pkg::MSG_DEMAND) begin
                     d.s = rate_repartition_pkg::S_CONF;
                     d.seq = rseq;
                  end else begin
                     d.seq = inc;
                  end
               end
               rate_repartition_pkg::S_CONF: begin
                  if (rtype == rate_repartition_pkg::MSG_EXEC) begin
                     d.s = rate_repartition_pkg::S_GO;
                     d.stx = 1'b1;
                     d.srx = 1'b1;
                     d.ev = 1'b1;
                     d.es = rseq;
                     d.seq = rate_repartition_pkg::SEQ_FIRST;
                  end else if (rtype == rate_repartition_pkg::MSG_MONITOR) begin
                     d.s = rate_repartition_pkg::S_IDLE;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end
               end
               rate_repartition_pkg::S_NRDY: begin
                  if (rtype == rate_repartition_pkg::MSG_MONITOR) begin
                     d.s = rate_repartition_pkg::S_IDLE;
                     d.ab = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end
               end
               rate_repartition_pkg::S_GO: begin
                  if (framer_ready) begin
                     d.s = rate_repartition_pkg::S_WMON;
                  end else if (rtype == rate_repartition_pkg::MSG_MONITOR
                        || rtype == rate_repartition_pkg::MSG_DEMAND) begin
                     d.s = rate_repartition_pkg::S_WFRM;
                  end else begin
                     d.seq = inc;
                     d.ov = (inc == rate_repartition_pkg::SEQ_MAX);
                  end
               end
               rate_repartition_pkg::S_WMON: begin
                  if (rtype == rate_repartition_pkg::MSG_MONITOR
                        || rtype == rate_repartition_pkg::MSG_DEMAND) begin
                     d.s = rate_repartition_pkg::S_IDLE;
                     d.dn = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end
               end
               rate_repartition_pkg::S_WFRM: begin
                  if (framer_ready) begin
                     d.s = rate_repartition_pkg::S_IDLE;
                     d.dn = 1'b1;
                     d.seq = rate_repartition_pkg::SEQ_IDLE;
                  end
               end
            endcase
         end
      end
      // Supervisory reset wins over all
      if (sup_reset) begin
         d.m = rate_repartition_pkg::M_IDLE;
         d.s = rate_repartition_pkg::S_IDLE;
         d.seq = rate_repartition_pkg::SEQ_IDLE;
         d.al = 1'b0;
         // Notifications of the dropped exchange are withheld
         d.stx = 1'b0;
         d.srx = 1'b0;
         d.dn = 1'b0;
         d.ab = 1'b0;
         d.nr = 1'b0;
         d.ev = 1'b0;
         d.ov = 1'b0;
      end
      // Outgoing message built from next state
      d.msg = '0;
      d.msg[SLOTS-1:0] = local_map;
      if (is_master) begin
         unique case (d.m)
            rate_repartition_pkg::M_IDLE: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_MONITOR;
            rate_repartition_pkg::M_INIT: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_DEMAND;
            rate_repartition_pkg::M_GO1, rate_repartition_pkg::M_GO2: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_EXEC;
         endcase
      end else begin
         unique case (d.s)
            rate_repartition_pkg::S_IDLE: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_MONITOR;
            rate_repartition_pkg::S_REQ: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_REQUEST;
            rate_repartition_pkg::S_CONF: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_DEMAND_ACK;
            rate_repartition_pkg::S_NRDY: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_DEMAND_NAK;
            rate_repartition_pkg::S_GO, rate_repartition_pkg::S_WMON,
            rate_repartition_pkg::S_WFRM: d.msg[W-1 -: 4] = rate_repartition_pkg::MSG_EXEC_ACK;
         endcase
      end
      d.msg[W-5 -: 4] = d.seq;
   end

   //==========================================================
   // State register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{m: rate_repartition_pkg::M_IDLE, s: rate_repartition_pkg::S_IDLE,
                msg: {rate_repartition_pkg::MSG_MONITOR, {(W-4){1'b0}}}, default: '0};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops; lead_time and zbit_count from parameters
   assign tx_msg = q.msg;
   assign start_tx_framer = q.stx;
   assign start_rx_framer = q.srx;
   assign done = q.dn;
   assign aborted = q.ab;
   assign not_ready = q.nr;
   assign overflow = q.ov;
   assign slot_alarm = q.al;
   assign exec_seq_valid = q.ev;
   assign exec_seq = q.es;
   assign lead_time = 4'(LEAD_TIME);
   assign zbit_count = 2'(ZBITS);

   //==========================================================
   // Checks
   AST_SEQ_SAT: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(q.seq) == rate_repartition_pkg::SEQ_MAX && q.seq != 4'h0 |-> q.seq == rate_repartition_pkg::SEQ_MAX
      || $past(superframe)) else $error("Sequence left saturation");
   AST_IDLE_MON: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_IDLE && !$past(superframe) |->
      q.msg[W-1 -: 4] == rate_repartition_pkg::MSG_MONITOR) else $error("Idle master not MONITOR");
   AST_ACK_GO1: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_INIT && superframe && !sup_reset
      && rtype == rate_repartition_pkg::MSG_DEMAND_ACK |=> q.m == rate_repartition_pkg::M_GO1 && q.stx
      && q.seq == 4'h1) else $error("DEMAND ACK not taken");
   AST_NAK_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_INIT && superframe && !sup_reset
      && rtype == rate_repartition_pkg::MSG_DEMAND_NAK |=> q.m == rate_repartition_pkg::M_IDLE && q.nr)
      else $error("DEMAND NAK not taken");
   AST_GO2_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
      q.m == rate_repartition_pkg::M_GO2 ##1 q.m == rate_repartition_pkg::M_GO2 |-> $stable(q.seq))
      else $error("EXEC count moved");
   AST_CONF_SEQ: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_IDLE && superframe && !sup_reset && slave_ready
      && rtype == rate_repartition_pkg::MSG_DEMAND |=> q.s == rate_repartition_pkg::S_CONF
      && q.msg[W-5 -: 4] == $past(rseq)) else $error("DEMAND ACK sequence wrong");
   AST_EXEC_REPORT: assert property (@(posedge sys_clk) disable iff (!nrst)
      q.ev |-> q.stx && q.srx && q.s == rate_repartition_pkg::S_GO) else $error("EXEC report wrong");
   AST_NRDY_ABORT: assert property (@(posedge sys_clk) disable iff (!nrst)
      q.ab |-> $past(q.s) == rate_repartition_pkg::S_NRDY && q.s == rate_repartition_pkg::S_IDLE)
      else $error("Abort without not-ready");
   AST_WAIT_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.dn |-> ($past(q.s) == rate_repartition_pkg::S_WMON
      || $past(q.s) == rate_repartition_pkg::S_WFRM)) else $error("Completion from wrong state");
   AST_NO_TICK: assert property (@(posedge sys_clk) disable iff (!nrst)
      !superframe && !sup_reset |=> $stable(q.m) && $stable(q.s)) else $error("Change off boundary");
   // Supervisory reset, per-superframe transitions, counters and notifications
   AST_SUP_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
      sup_reset |=> q.m == rate_repartition_pkg::M_IDLE && q.s == rate_repartition_pkg::S_IDLE
      && q.seq == rate_repartition_pkg::SEQ_IDLE && !q.stx && !q.srx && !q.dn && !q.ev)
      else $error("Supervisory reset not idle");
   AST_MST_START: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_IDLE && superframe && !sup_reset && (sup_start
      || rtype == rate_repartition_pkg::MSG_REQUEST) |=> q.m == rate_repartition_pkg::M_INIT
      && q.seq == rate_repartition_pkg::SEQ_FIRST) else $error("Master start not taken");
   AST_SLOT_ALARM: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_IDLE && superframe && !sup_reset
      && rtype == rate_repartition_pkg::MSG_MONITOR && rx[SLOTS-1:0] != local_map |=> q.al)
      else $error("Slot map mismatch not flagged");
   AST_DEMAND_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_INIT && superframe && !sup_reset
      && q.seq != rate_repartition_pkg::SEQ_MAX && rtype != rate_repartition_pkg::MSG_DEMAND_ACK
      && rtype != rate_repartition_pkg::MSG_DEMAND_NAK |=> q.seq == $past(q.seq) + 4'h1)
      else $error("DEMAND count not stepped");
   AST_DEMAND_SAT: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_INIT && superframe && !sup_reset
      && q.seq == rate_repartition_pkg::SEQ_MAX && rtype != rate_repartition_pkg::MSG_DEMAND_ACK
      && rtype != rate_repartition_pkg::MSG_DEMAND_NAK |=> q.seq == rate_repartition_pkg::SEQ_MAX && q.ov)
      else $error("DEMAND count left saturation");
   AST_EXEC_ACK_GO2: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_GO1 && superframe && !sup_reset
      && rtype == rate_repartition_pkg::MSG_EXEC_ACK |=> q.m == rate_repartition_pkg::M_GO2 && q.srx
      && $stable(q.seq)) else $error("EXEC ACK not taken");
   AST_GO2_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
      is_master && q.m == rate_repartition_pkg::M_GO2 && superframe && !sup_reset && framer_ready
      |=> q.m == rate_repartition_pkg::M_IDLE && q.dn && q.seq == rate_repartition_pkg::SEQ_IDLE)
      else $error("Master completion missing");
   AST_IDLE_MSG: assert property (@(posedge sys_clk) disable iff (!nrst)
      q.m == rate_repartition_pkg::M_IDLE && q.s == rate_repartition_pkg::S_IDLE
      |-> q.msg[W-1:W-8] == {rate_repartition_pkg::MSG_MONITOR, rate_repartition_pkg::SEQ_IDLE})
      else $error("Idle not MONITOR 0");
   AST_SLV_REFUSE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_IDLE && superframe && !sup_reset && !slave_ready
      && rtype == rate_repartition_pkg::MSG_DEMAND |=> q.s == rate_repartition_pkg::S_NRDY
      && q.seq == $past(rseq)) else $error("Not-ready DEMAND not refused");
   AST_SLV_REQUEST: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_IDLE && superframe && !sup_reset && slave_ready
      && slave_request && rtype != rate_repartition_pkg::MSG_DEMAND |=> q.s == rate_repartition_pkg::S_REQ
      && q.seq == rate_repartition_pkg::SEQ_FIRST) else $error("Slave request not started");
   AST_SLV_GO_WAIT: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_GO && superframe && !sup_reset && framer_ready
      |=> q.s == rate_repartition_pkg::S_WMON && $stable(q.seq)) else $error("Framer ready not taken");
   AST_EXEC_ACK_SAT: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_GO && superframe && !sup_reset && !framer_ready
      && q.seq == rate_repartition_pkg::SEQ_MAX && rtype != rate_repartition_pkg::MSG_MONITOR
      && rtype != rate_repartition_pkg::MSG_DEMAND |=> q.seq == rate_repartition_pkg::SEQ_MAX && q.ov)
      else $error("EXEC ACK count left saturation");
   AST_WFRM_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !is_master && q.s == rate_repartition_pkg::S_WFRM && superframe && !sup_reset && framer_ready
      |=> q.s == rate_repartition_pkg::S_IDLE && q.dn) else $error("Slave completion missing");
endmodule

// ---- verification/peer_repartition_model.sv ----
`timescale 1ns/1ps
//==============================================================
// Peer unit: frames one message and sends three copies of it
module peer_repartition_model #(
   parameter int W = 16
) (
   input wire logic [3:0] msg_type,
   input wire logic [3:0] msg_seq,
   input wire logic [W-9:0] msg_map,
   input wire logic [1:0] bad_copy,
   output logic [W-1:0] copy0,
   output logic [W-1:0] copy1,
   output logic [W-1:0] copy2
);
   logic [W-1:0] msg;
   // Type nibble on top, then sequence nibble, then slot map
   assign msg = {msg_type, msg_seq, msg_map};
   // Line noise inverts at most one copy, so two always agree
   assign copy0 = (bad_copy == 2'h0) ? ~msg : msg;
   assign copy1 = (bad_copy == 2'h1) ? ~msg : msg;
   assign copy2 = (bad_copy == 2'h2) ? ~msg : msg;
endmodule

// ---- verification/test_rate_repartition.sv ----
`timescale 1ns/1ps
//==============================================================
// Bench: drives one superframe at a time and checks the answer
module test_rate_repartition;
   localparam int W = 16;
   localparam logic [3:0] MON = rate_repartition_pkg::MSG_MONITOR;
   localparam logic [3:0] DEM = rate_repartition_pkg::MSG_DEMAND;
   localparam logic [3:0] DACK = rate_repartition_pkg::MSG_DEMAND_ACK;
   localparam logic [3:0] DNAK = rate_repartition_pkg::MSG_DEMAND_NAK;
   localparam logic [3:0] EXE = rate_repartition_pkg::MSG_EXEC;
   localparam logic [3:0] EACK = rate_repartition_pkg::MSG_EXEC_ACK;
   localparam logic [3:0] REQ = rate_repartition_pkg::MSG_REQUEST;
   localparam logic [6:0] E_TX = 7'h40;
   localparam logic [6:0] E_RX = 7'h20;
   localparam logic [6:0] E_DN = 7'h10;
   localparam logic [6:0] E_AB = 7'h08;
   localparam logic [6:0] E_NR = 7'h04;
   localparam logic [6:0] E_OV = 7'h02;
   localparam logic [6:0] E_ES = 7'h01;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic is_master = 1'b1;
   logic superframe = 1'b0;
   logic sup_reset = 1'b0;
   logic sup_start = 1'b0;
   logic slave_ready = 1'b0;
   logic slave_request = 1'b0;
   logic framer_ready = 1'b0;
   logic [7:0] local_map = 8'h5a;
   logic [3:0] rx_type = 4'hf;
   logic [3:0] rx_seq = 4'h0;
   logic [7:0] rx_map = 8'h5a;
   logic [1:0] bad = 2'h3;
   logic [W-1:0] c0, c1, c2, tx_msg;
   logic [3:0] exec_seq, lead_time;
   logic [1:0] zbit_count;
   logic slot_alarm;
   logic [6:0] ev;
   int mismatches = 0;
   int n_checks = 0;
   int i;

   //==============================================================
   // Design and peer
   rate_repartition #(.SLOTS(8), .ZBITS(2), .LEAD_TIME(3)) rate_repartition_i (
      .sys_clk(sys_clk), .nrst(nrst), .is_master(is_master), .superframe(superframe),
      .sup_reset(sup_reset), .sup_start(sup_start), .slave_ready(slave_ready),
      .slave_request(slave_request), .framer_ready(framer_ready), .local_map(local_map),
      .rx_copy0(c0), .rx_copy1(c1), .rx_copy2(c2), .tx_msg(tx_msg),
      .start_tx_framer(ev[6]), .start_rx_framer(ev[5]), .done(ev[4]), .aborted(ev[3]),
      .not_ready(ev[2]), .overflow(ev[1]), .slot_alarm(slot_alarm), .exec_seq_valid(ev[0]),
      .exec_seq(exec_seq), .lead_time(lead_time), .zbit_count(zbit_count));
   peer_repartition_model #(.W(W)) peer_repartition_model_i (
      .msg_type(rx_type), .msg_seq(rx_seq), .msg_map(rx_map), .bad_copy(bad),
      .copy0(c0), .copy1(c1), .copy2(c2));

   //==============================================================
   // Clock and hang guard
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end

   //==============================================================
   // Tasks
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One superframe with the peer message; ctl bit1 orders a start, bit0 framer ready
   task automatic step(input logic [3:0] t, input logic [3:0] s, input logic [1:0] ctl,
                       input logic [3:0] et, input logic [3:0] es, input logic [6:0] ee);
      @(posedge sys_clk);
      superframe <= 1'b1;
      rx_type <= t;
      rx_seq <= s;
      sup_start <= ctl[1];
      framer_ready <= ctl[0];
      bad <= bad + 2'h1;
      @(posedge sys_clk);
      superframe <= 1'b0;
      sup_start <= 1'b0;
      framer_ready <= 1'b0;
      #1;
      chk(tx_msg, {et, es, local_map});
      chk(W'(ev), W'(ee));
   endtask

   //==============================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      chk(W'({zbit_count, lead_time}), W'({2'h2, 4'h3}));
      @(posedge sys_clk);
      rx_map <= 8'h5b;
      step(MON, 4'h0, 2'h0, MON, 4'h0, 7'h00);
      chk(W'(slot_alarm), W'(1'b1));
      @(posedge sys_clk);
      rx_map <= 8'h5a;
      step(MON, 4'h0, 2'h0, MON, 4'h0, 7'h00);
      chk(W'(slot_alarm), W'(1'b0));
      // Master: full exchange
      step(MON, 4'h0, 2'h2, DEM, 4'h1, 7'h00);
      step(MON, 4'h0, 2'h0, DEM, 4'h2, 7'h00);
      step(DACK, 4'h2, 2'h0, EXE, 4'h1, E_TX);
      step(DACK, 4'h2, 2'h0, EXE, 4'h2, 7'h00);
      step(EACK, 4'h1, 2'h0, EXE, 4'h2, E_RX);
      step(EACK, 4'h2, 2'h0, EXE, 4'h2, 7'h00);
      step(EACK, 4'h3, 2'h1, MON, 4'h0, E_DN);
      // Master: slave request, counter saturation, refusal
      step(REQ, 4'h1, 2'h0, DEM, 4'h1, 7'h00);
      for (i = 2; i < 17; i++) begin
         step(MON, 4'h0, 2'h0, DEM, (i > 15) ? 4'hf : 4'(i), (i > 14) ? E_OV : 7'h00);
      end
      step(DNAK, 4'hf, 2'h0, MON, 4'h0, E_NR);
      step(MON, 4'h0, 2'h2, DEM, 4'h1, 7'h00);
      // Supervisory reset drops the exchange and hands over to the slave machine
      @(posedge sys_clk);
      is_master <= 1'b0;
      sup_reset <= 1'b1;
      @(posedge sys_clk);
      sup_reset <= 1'b0;
      #1;
      chk(tx_msg, {MON, 4'h0, local_map});
      // Slave: not ready, then abort; nothing moves without a superframe
      step(DEM, 4'h3, 2'h0, DNAK, 4'h3, 7'h00);
      step(DEM, 4'h4, 2'h0, DNAK, 4'h3, 7'h00);
      step(MON, 4'h0, 2'h0, MON, 4'h0, E_AB);
      @(posedge sys_clk);
      slave_ready <= 1'b1;
      rx_type <= DEM;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(tx_msg, {MON, 4'h0, local_map});
      // Slave: own request, confirmation, wait for monitor
      @(posedge sys_clk);
      slave_request <= 1'b1;
      step(MON, 4'h0, 2'h0, REQ, 4'h1, 7'h00);
      @(posedge sys_clk);
      slave_request <= 1'b0;
      step(MON, 4'h0, 2'h0, REQ, 4'h2, 7'h00);
      step(DEM, 4'h5, 2'h0, DACK, 4'h5, 7'h00);
      step(DEM, 4'h6, 2'h0, DACK, 4'h5, 7'h00);
      step(EXE, 4'h2, 2'h0, EACK, 4'h1, E_TX | E_RX | E_ES);
      chk(W'(exec_seq), W'(4'h2));
      step(EXE, 4'h3, 2'h0, EACK, 4'h2, 7'h00);
      step(EXE, 4'h4, 2'h1, EACK, 4'h2, 7'h00);
      step(DEM, 4'h1, 2'h0, MON, 4'h0, E_DN);
      // Slave: counter saturation, wait for framer
      step(DEM, 4'h1, 2'h0, DACK, 4'h1, 7'h00);
      step(EXE, 4'h1, 2'h0, EACK, 4'h1, E_TX | E_RX | E_ES);
      for (i = 2; i < 17; i++) begin
         step(EXE, 4'h1, 2'h0, EACK, (i > 15) ? 4'hf : 4'(i), (i > 14) ? E_OV : 7'h00);
      end
      step(MON, 4'h0, 2'h0, EACK, 4'hf, 7'h00);
      step(MON, 4'h0, 2'h0, EACK, 4'hf, 7'h00);
      step(MON, 4'h0, 2'h1, MON, 4'h0, E_DN);
      print_verdict();
   end
endmodule
